//--- plm_pkg.sv
// shared constants and types for the pixel link framing block
package plm_pkg;
    // one pixel as it enters the serializer or leaves the deserializer
    typedef struct packed {
        logic de;
        logic vs;
        logic hs;
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } plm_pixel_t;

    // link lanes for one link clock: index 0 is the data line, 1 the sequence line
    typedef struct packed {
        logic [1:0] fall;
        logic [1:0] rise;
    } plm_lanes_t;

    // deserializer framing states, codes written out
    typedef enum logic [1:0] {
        ST_VERIFY = 2'b00,
        ST_SYNC = 2'b01,
        ST_SEARCH = 2'b10
    } plm_state_t;

    localparam int unsigned PIX_W = 21;
    localparam int unsigned HALF_W = 12;
    localparam int unsigned CAND_N = 6;
    localparam int unsigned POS_PAR = 21;
    localparam int unsigned POS_F_LSB = 22;
    localparam int unsigned POS_F_MSB = 23;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h5;
    localparam logic [2:0] SLOT_CLK_SET_LO = 3'h2;
    localparam logic [2:0] SLOT_CLK_SET_HI = 3'h4;
    localparam logic [2:0] SLOT_PE_SET_LO = 3'h0;
    localparam logic [2:0] SLOT_PE_SET_HI = 3'h2;
    localparam logic [1:0] SEQ_STEP = 2'h1;
    localparam logic [3:0] HYST_DEFAULT = 4'h8;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [5:0] FLAGS_ALL = 6'h3f;
endpackage

//--- plm_frame_sync.sv
// framing, sequence tracking and sync recovery for the three-line pixel link
// How it works
// - off phase: all link line drivers disabled, no line current
// - receiver ignores link lines while off, so the turn-off glitch is no data
// - serializer samples pixel each strobe; deserializer replays it unchanged
// - one pixel is six link clocks, both edges, two lines, 24 bits
// - frame carries enable, parity and a two-bit sequence field
// - parity is odd over colour, vertical, horizontal sync and enable
// - each parity-failed frame that keeps sync gives a three link clock fault pulse
// - fault pulse spans two link clocks before, one after pixel clock rise
// - sequence field increments by one each pixel, repeating every four
// - after power-up start aligned, confirm N pixels before output
// - bad sequence decrements hysteresis, output continues; good one restores maximum
// - hysteresis at zero blanks data, holds pixel clock low, starts search
// - search looks at the sequence line only
// - six candidate pairs incremented and compared to next 12 bits until one left
// - lone candidate verified for N pixels before sync and output resume
// - serializer runs link clock at six per pixel while powered
// - power-down drives deserializer outputs and forward output low
`timescale 1ns/1ps
module plm_frame_sync
#(
    parameter logic [3:0] P_HYST_N = plm_pkg::HYST_DEFAULT
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_link_clk,
    input wire logic i_power_down_n,
    input wire logic i_serializer_mode,
    input wire logic i_pix_stb,
    input wire plm_pkg::plm_pixel_t i_pix,
    input wire plm_pkg::plm_lanes_t i_rx_lanes,
    output logic o_power_down_forward_n,
    output logic o_link_clock_line_en,
    output logic o_link_clock_line_oe,
    output plm_pkg::plm_lanes_t o_tx_lanes,
    output logic [1:0] o_link_data_lines_oe,
    output plm_pkg::plm_pixel_t o_pix,
    output logic o_pclk,
    output logic o_parity_fault_pulse
);
    // pair of one lane at link clock idx within a 12-bit half frame
    function automatic logic [1:0] lane_pair(input logic [11:0] half, input logic [2:0] idx);
        lane_pair = half[{idx, 1'b0} +: 2];
    endfunction

    // parity bit that makes the pixel plus parity odd
    function automatic logic odd_par(input plm_pkg::plm_pixel_t pix);
        odd_par = ~(^pix);
    endfunction

    // pixel clock side: pin syncs and capture
    logic pd_meta_reg;
    logic pd_reg;
    logic mode_meta_reg;
    logic mode_reg;
    logic cap_tgl_reg;
    plm_pkg::plm_pixel_t cap_reg;

    // pins pass two flops before use
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pd_meta_reg <= 1'b0;
            pd_reg <= 1'b0;
            mode_meta_reg <= 1'b0;
            mode_reg <= 1'b0;
        end
        else
        begin
            pd_meta_reg <= i_power_down_n;
            pd_reg <= pd_meta_reg;
            mode_meta_reg <= i_serializer_mode;
            mode_reg <= mode_meta_reg;
        end
    end

    // capture a pixel per strobe; toggle tells the link side a word is ready
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cap_reg <= '0;
            cap_tgl_reg <= 1'b0;
            o_power_down_forward_n <= 1'b0;
        end
        else
        begin
            o_power_down_forward_n <= pd_reg & mode_reg;
            if (i_pix_stb && pd_reg)
            begin
                cap_reg <= i_pix;
                cap_tgl_reg <= ~cap_tgl_reg;
            end
        end
    end

    // link side: syncs of power-down, mode and capture toggle
    logic lpd_meta_reg;
    logic lpd_reg;
    logic lmode_meta_reg;
    logic lmode_reg;
    logic ltgl_meta_reg;
    logic ltgl_reg;
    logic ltgl_d_reg;
    plm_pkg::plm_pixel_t hold_reg;

    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            lpd_meta_reg <= 1'b0;
            lpd_reg <= 1'b0;
            lmode_meta_reg <= 1'b0;
            lmode_reg <= 1'b0;
            ltgl_meta_reg <= 1'b0;
            ltgl_reg <= 1'b0;
            ltgl_d_reg <= 1'b0;
        end
        else
        begin
            lpd_meta_reg <= i_power_down_n;
            lpd_reg <= lpd_meta_reg;
            lmode_meta_reg <= i_serializer_mode;
            lmode_reg <= lmode_meta_reg;
            ltgl_meta_reg <= cap_tgl_reg;
            ltgl_reg <= ltgl_meta_reg;
            ltgl_d_reg <= ltgl_reg;
        end
    end

    wire ser_run = lpd_reg & lmode_reg;
    wire des_run = lpd_reg & ~lmode_reg;
    wire new_word = ltgl_reg ^ ltgl_d_reg;

    // cap_reg is stable here: it changed two link clocks before the toggle arrived
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            hold_reg <= '0;
        else if (new_word)
            hold_reg <= cap_reg;
    end

    // serializer: slot counter, sequence and frame word
    logic [2:0] tx_slot_reg;
    logic [1:0] seq_reg;
    logic [23:0] word_reg;
    wire tx_last = tx_slot_reg == plm_pkg::SLOT_LAST;
    wire [2:0] tx_slot_next = tx_last ? plm_pkg::SLOT_FIRST : tx_slot_reg + 3'h1;
    wire [23:0] tx_word = {seq_reg, odd_par(hold_reg), hold_reg};
    // sequence-line pair for the current slot, named so the lane driver can split it
    wire [1:0] tx_pair1 = lane_pair(word_reg[23:12], tx_slot_reg);

    // repeats the last pixel if the host is slower than the frame rate
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_slot_reg <= plm_pkg::SLOT_FIRST;
            seq_reg <= '0;
            word_reg <= '0;
        end
        else if (!ser_run)
        begin
            tx_slot_reg <= plm_pkg::SLOT_FIRST;
            seq_reg <= '0;
            word_reg <= '0;
        end
        else
        begin
            tx_slot_reg <= tx_slot_next;
            if (tx_last)
            begin
                word_reg <= tx_word;
                seq_reg <= seq_reg + plm_pkg::SEQ_STEP;
            end
        end
    end

    // lane drivers: one pipeline stage after the slot count
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_tx_lanes <= '0;
            o_link_clock_line_en <= 1'b0;
            o_link_clock_line_oe <= 1'b0;
            o_link_data_lines_oe <= '0;
        end
        else
        begin
            o_link_clock_line_en <= ser_run;
            o_link_clock_line_oe <= ser_run;
            o_link_data_lines_oe <= {ser_run, ser_run};
            o_tx_lanes.rise[0] <= ser_run & word_reg[{tx_slot_reg, 1'b0}];
            o_tx_lanes.fall[0] <= ser_run & word_reg[{tx_slot_reg, 1'b1}];
            o_tx_lanes.rise[1] <= ser_run & tx_pair1[0];
            o_tx_lanes.fall[1] <= ser_run & tx_pair1[1];
        end
    end

    // deserializer: lane pins pass two flops
    plm_pkg::plm_lanes_t rx_meta_reg;
    plm_pkg::plm_lanes_t rx_reg;
    logic [11:0] rx0_sr_reg;
    logic [11:0] rx1_sr_reg;

    // half frames with this cycle's bits shifted in at the top
    wire [11:0] rx0_n = {rx_reg.fall[0], rx_reg.rise[0], rx0_sr_reg[11:2]};
    wire [11:0] rx1_n = {rx_reg.fall[1], rx_reg.rise[1], rx1_sr_reg[11:2]};

    // while off, lanes read as zero so the turn-off glitch never reaches framing
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rx_meta_reg <= '0;
            rx_reg <= '0;
            rx0_sr_reg <= '0;
            rx1_sr_reg <= '0;
        end
        else
        begin
            rx_meta_reg <= i_rx_lanes;
            rx_reg <= des_run ? rx_meta_reg : '0;
            rx0_sr_reg <= des_run ? rx0_n : '0;
            rx1_sr_reg <= des_run ? rx1_n : '0;
        end
    end

    wire [23:0] word_in = {rx1_n, rx0_n};
    wire plm_pkg::plm_pixel_t pix_in = word_in[plm_pkg::PIX_W-1:0];
    wire [1:0] f_in = word_in[plm_pkg::POS_F_MSB:plm_pkg::POS_F_LSB];
    wire par_ok = ^word_in[plm_pkg::POS_PAR:0];

    // framing state
    plm_pkg::plm_state_t state_reg;
    logic [2:0] rx_slot_reg;
    logic [3:0] hyst_reg;
    logic [3:0] ver_reg;
    logic [1:0] f_prev_reg;
    logic [5:0] flags_reg;
    logic [11:0] snap_reg;
    logic snap_ok_reg;

    wire frame_end = des_run && rx_slot_reg == plm_pkg::SLOT_LAST;
    wire [2:0] rx_slot_next = frame_end ? plm_pkg::SLOT_FIRST : rx_slot_reg + 3'h1;
    wire [1:0] f_expect = f_prev_reg + plm_pkg::SEQ_STEP;
    wire f_ok = f_in == f_expect;
    wire seed = ver_reg == '0;
    wire [3:0] ver_inc = ver_reg + plm_pkg::CNT_ONE;
    wire [3:0] hyst_dec = hyst_reg - plm_pkg::CNT_ONE;

    // search candidates watch the sequence line only
    logic [5:0] match;
    genvar gk;
    generate
        for (gk = 0; gk < plm_pkg::CAND_N; gk = gk + 1)
        begin : g_cand
            assign match[gk] = lane_pair(rx1_n, 3'(gk)) == 2'(lane_pair(snap_reg, 3'(gk)) + plm_pkg::SEQ_STEP);
        end
    endgenerate

    wire [5:0] survivors = flags_reg & match;
    wire lone = survivors != '0 && (survivors & 6'(survivors - 6'h1)) == '0;
    logic [2:0] hit_idx;

    // index of the surviving candidate
    always_comb
    begin
        hit_idx = '0;
        for (int k = 0; k < plm_pkg::CAND_N; k++)
        begin
            if (survivors[k])
                hit_idx = 3'(k);
        end
    end

    // realign so that the surviving pair lands in the last slot
    wire [2:0] realign = plm_pkg::SLOT_LAST - hit_idx;
    wire [1:0] hit_f = lane_pair(rx1_n, hit_idx);

    // framing state machine
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg <= plm_pkg::ST_VERIFY;
            rx_slot_reg <= plm_pkg::SLOT_FIRST;
            hyst_reg <= '0;
            ver_reg <= '0;
            f_prev_reg <= '0;
            flags_reg <= plm_pkg::FLAGS_ALL;
            snap_reg <= '0;
            snap_ok_reg <= 1'b0;
        end
        else if (!des_run)
        begin
            state_reg <= plm_pkg::ST_VERIFY;
            rx_slot_reg <= plm_pkg::SLOT_FIRST;
            hyst_reg <= '0;
            ver_reg <= '0;
            flags_reg <= plm_pkg::FLAGS_ALL;
            snap_ok_reg <= 1'b0;
        end
        else
        begin
            rx_slot_reg <= rx_slot_next;
            case (state_reg)
                plm_pkg::ST_VERIFY:
                    if (frame_end)
                    begin
                        f_prev_reg <= f_in;
                        if (seed || f_ok)
                        begin
                            ver_reg <= ver_inc;
                            if (ver_inc == P_HYST_N)
                            begin
                                state_reg <= plm_pkg::ST_SYNC;
                                hyst_reg <= P_HYST_N;
                            end
                        end
                        else
                        begin
                            state_reg <= plm_pkg::ST_SEARCH;
                            snap_ok_reg <= 1'b0;
                        end
                    end
                plm_pkg::ST_SYNC:
                    if (frame_end)
                    begin
                        // a single bad field free-wheels the expected value
                        f_prev_reg <= f_ok ? f_in : f_expect;
                        if (f_ok)
                            hyst_reg <= P_HYST_N;
                        else
                        begin
                            hyst_reg <= hyst_dec;
                            if (hyst_dec == '0)
                            begin
                                state_reg <= plm_pkg::ST_SEARCH;
                                snap_ok_reg <= 1'b0;
                            end
                        end
                    end
                plm_pkg::ST_SEARCH:
                    if (frame_end)
                    begin
                        snap_reg <= rx1_n;
                        snap_ok_reg <= 1'b1;
                        if (!snap_ok_reg || survivors == '0)
                            flags_reg <= plm_pkg::FLAGS_ALL;
                        else if (lone)
                        begin
                            state_reg <= plm_pkg::ST_VERIFY;
                            rx_slot_reg <= realign;
                            f_prev_reg <= hit_f;
                            ver_reg <= plm_pkg::CNT_ONE;
                            flags_reg <= plm_pkg::FLAGS_ALL;
                        end
                        else
                            flags_reg <= survivors;
                    end
                default:
                    state_reg <= plm_pkg::ST_SEARCH;
            endcase
        end
    end

    // output staging: pixel changes at slot 0, clock high slots 3..5, fault slots 1..3
    wire in_sync = des_run && state_reg == plm_pkg::ST_SYNC;
    wire keep_sync = in_sync && (f_ok || hyst_dec != '0);
    wire clk_win = rx_slot_reg >= plm_pkg::SLOT_CLK_SET_LO && rx_slot_reg <= plm_pkg::SLOT_CLK_SET_HI;
    wire pe_win = rx_slot_reg >= plm_pkg::SLOT_PE_SET_LO && rx_slot_reg <= plm_pkg::SLOT_PE_SET_HI;
    logic pe_flag_reg;

    // blanked outputs whenever not in sync or powered down
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pix <= '0;
            o_pclk <= 1'b0;
            o_parity_fault_pulse <= 1'b0;
            pe_flag_reg <= 1'b0;
        end
        else if (!in_sync)
        begin
            o_pix <= '0;
            o_pclk <= 1'b0;
            o_parity_fault_pulse <= 1'b0;
            pe_flag_reg <= 1'b0;
        end
        else
        begin
            if (frame_end)
            begin
                o_pix <= keep_sync ? pix_in : '0;
                pe_flag_reg <= keep_sync & ~par_ok;
            end
            o_pclk <= clk_win && !(frame_end && !keep_sync);
            o_parity_fault_pulse <= pe_win & pe_flag_reg;
        end
    end
endmodule

//--- plm_frame_sync_monitor.sv
// port-level checks for the pixel link framing block
`timescale 1ns/1ps
module plm_frame_sync_monitor
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_link_clk,
    input wire logic i_power_down_n,
    input wire logic i_serializer_mode,
    input wire logic o_power_down_forward_n,
    input wire logic o_link_clock_line_en,
    input wire logic o_link_clock_line_oe,
    input wire plm_pkg::plm_lanes_t o_tx_lanes,
    input wire logic [1:0] o_link_data_lines_oe,
    input wire plm_pkg::plm_pixel_t o_pix,
    input wire logic o_pclk,
    input wire logic o_parity_fault_pulse
);
    // power-down effects get four cycles: two sync stages, the output flop and the sampling edge
    AST_OFF_LINES: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
        (!i_power_down_n)[*4] |-> !o_link_clock_line_en && !o_link_clock_line_oe
        && o_link_data_lines_oe == 2'h0 && o_tx_lanes == 4'h0) else $error("link lines driven while off");
    AST_PD_QUIET: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
        (!i_power_down_n)[*4] |-> o_pix == 21'h0 && !o_pclk && !o_parity_fault_pulse)
        else $error("display outputs active while off");
    AST_PD_FORWARD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_power_down_n)[*4] |-> !o_power_down_forward_n) else $error("forward output high while off");
    AST_CLK_RUN: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
        (i_serializer_mode && i_power_down_n)[*8] |-> o_link_clock_line_en) else $error("link clock stopped");
    // pulse shapes; a power-down cuts them short, so it aborts the check
    AST_FAULT_WIDTH: assert property (@(posedge i_link_clk) disable iff (!i_arst_n || !i_power_down_n)
        $rose(o_parity_fault_pulse) |-> o_parity_fault_pulse[*3] ##1 !o_parity_fault_pulse)
        else $error("fault pulse not three cycles");
    AST_FAULT_ALIGN: assert property (@(posedge i_link_clk) disable iff (!i_arst_n || !i_power_down_n)
        $rose(o_parity_fault_pulse) |-> ##2 $rose(o_pclk)) else $error("fault pulse misaligned to pclk");
    AST_PCLK_SHAPE: assert property (@(posedge i_link_clk) disable iff (!i_arst_n || !i_power_down_n)
        $rose(o_pclk) |-> o_pclk[*3] ##1 !o_pclk) else $error("pclk high time wrong");
    AST_PIX_STROBE: assert property (@(posedge i_link_clk) disable iff (!i_arst_n || !i_power_down_n)
        $changed(o_pix) && o_pix != 21'h0 |-> ##3 $rose(o_pclk)) else $error("pixel without strobe");
    // main scenarios reached
    COV_FAULT: cover property (@(posedge i_link_clk) $rose(o_parity_fault_pulse));
    COV_PCLK: cover property (@(posedge i_link_clk) $rose(o_pclk));
    COV_FWD: cover property (@(posedge i_clk) $fell(o_power_down_forward_n));
endmodule

bind plm_frame_sync plm_frame_sync_monitor u_monitor
(
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
    .i_power_down_n(i_power_down_n), .i_serializer_mode(i_serializer_mode),
    .o_power_down_forward_n(o_power_down_forward_n), .o_link_clock_line_en(o_link_clock_line_en),
    .o_link_clock_line_oe(o_link_clock_line_oe), .o_tx_lanes(o_tx_lanes),
    .o_link_data_lines_oe(o_link_data_lines_oe), .o_pix(o_pix), .o_pclk(o_pclk),
    .o_parity_fault_pulse(o_parity_fault_pulse)
);

//--- plm_link_src.sv
// behavioural far-end serializer driving the link lanes
`timescale 1ns/1ps
module plm_link_src
(
    input wire logic i_link_clk,
    input wire logic i_arst_n,
    input wire logic i_en,
    input wire plm_pkg::plm_pixel_t i_pix,
    input wire logic i_bad_seq,
    input wire logic i_bad_par,
    output plm_pkg::plm_lanes_t o_lanes,
    output logic o_frame_end
);
    logic [2:0] slot_reg;
    logic [1:0] seq_reg;
    logic [23:0] word_reg;
    logic [23:0] word_next;
    // odd parity over pixel bits; error knobs skew sequence or parity
    assign word_next = {seq_reg + {i_bad_seq, 1'b0}, ~^i_pix ^ i_bad_par, i_pix};
    assign o_frame_end = (slot_reg == 3'h5);
    // six link cycles a pixel, four bits a cycle
    always_ff @(posedge i_link_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            slot_reg <= 3'h0;
            seq_reg <= 2'h0;
            word_reg <= 24'h00_0000;
            o_lanes <= 4'h0;
        end
        else
        begin
            slot_reg <= o_frame_end ? 3'h0 : slot_reg + 3'h1;
            if (o_frame_end)
            begin
                word_reg <= word_next;
                seq_reg <= seq_reg + 2'h1;
            end
            // released lines toggle so a stale level never looks valid
            if (!i_en)
                o_lanes <= ~o_lanes;
            else
                o_lanes <= {word_reg[13 + 2 * slot_reg], word_reg[1 + 2 * slot_reg],
                    word_reg[12 + 2 * slot_reg], word_reg[2 * slot_reg]};
        end
    end
endmodule

//--- tb_pixel_link_frame_sync.sv
// testbench: deserializer fed by the model, then by a serializer instance
`timescale 1ns/1ps
module tb_pixel_link_frame_sync;
    logic clk, lclk, arst_n, pd_n, sel_ser, stb, bad_seq, bad_par;
    logic pclk_q, fault_q, d_pclk, d_fault, m_end, s_fwd;
    plm_pkg::plm_pixel_t pix, spix, d_pix;
    plm_pkg::plm_lanes_t m_lanes, s_lanes, rx_lanes;
    plm_pkg::plm_pixel_t notes[$];
    int bad_count, compares, seed, rises, faults;

    // deserializer input comes from the model or the serializer instance
    assign rx_lanes = sel_ser ? s_lanes : m_lanes;
    plm_link_src u_src
    (
        .i_link_clk(lclk), .i_arst_n(arst_n), .i_en(pd_n), .i_pix(pix),
        .i_bad_seq(bad_seq), .i_bad_par(bad_par), .o_lanes(m_lanes), .o_frame_end(m_end)
    );
    plm_frame_sync #(.P_HYST_N(4'h4)) dut
    (
        .i_clk(clk), .i_arst_n(arst_n), .i_link_clk(lclk), .i_power_down_n(pd_n),
        .i_serializer_mode(1'b0), .i_pix_stb(1'b0), .i_pix(21'h0), .i_rx_lanes(rx_lanes),
        .o_power_down_forward_n(), .o_link_clock_line_en(), .o_link_clock_line_oe(),
        .o_tx_lanes(), .o_link_data_lines_oe(), .o_pix(d_pix), .o_pclk(d_pclk),
        .o_parity_fault_pulse(d_fault)
    );
    plm_frame_sync dut_ser
    (
        .i_clk(clk), .i_arst_n(arst_n), .i_link_clk(lclk), .i_power_down_n(pd_n),
        .i_serializer_mode(1'b1), .i_pix_stb(stb), .i_pix(spix), .i_rx_lanes(m_lanes),
        .o_power_down_forward_n(s_fwd), .o_link_clock_line_en(), .o_link_clock_line_oe(),
        .o_tx_lanes(s_lanes), .o_link_data_lines_oe(), .o_pix(), .o_pclk(),
        .o_parity_fault_pulse()
    );

    // two unrelated clocks
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        lclk = 1'b0;
        #3.3;
        forever #6 lclk = ~lclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // error knobs for the frame the model latches next
    task automatic frame(input logic s, input logic p);
        @(posedge lclk iff m_end);
        bad_seq <= s;
        bad_par <= p;
    endtask

    task automatic wait_sync();
        int r0;
        r0 = rises;
        for (int i = 0; i < 1000 && rises == r0; i++) @(posedge lclk);
        check("sync found", rises != r0, 1'b1);
    endtask

    // rises counted after the edge settles, so no race with the watcher
    task automatic count_rises(input int n, input int exp, input string what);
        int r0;
        @(posedge lclk iff m_end);
        #1;
        r0 = rises;
        repeat (n) @(posedge lclk);
        #1;
        check(what, rises - r0, exp);
    endtask

    // random pixel held steady, then four strobes expected to carry it
    task automatic stream(input int n);
        logic [31:0] rnd;
        repeat (n)
        begin
            rnd = $random(seed);
            // host pixels carry 5-6-5 colour: left-aligned, low red and blue bits tied low
            if (sel_ser)
                rnd = rnd & 32'h001F_EFFE;
            if (sel_ser)
            begin
                @(posedge clk);
                spix <= rnd[20:0];
                // one strobe per five frames or more keeps the pixel rate inside the host range
                stb <= 1'b1;
                @(posedge clk);
                stb <= 1'b0;
            end
            else
                pix <= rnd[20:0];
            repeat (5) @(posedge lclk iff m_end);
            repeat (4) notes.push_back(rnd[20:0]);
            for (int i = 0; i < 60 && notes.size() > 0; i++) @(posedge lclk);
            check("notes left", notes.size(), 0);
        end
    endtask

    // watcher: one note taken at every output pixel strobe while any notes are queued
    always @(posedge lclk)
    begin
        if (d_pclk === 1'b1 && pclk_q === 1'b0)
        begin
            rises++;
            if (notes.size() > 0)
                check("o_pix", d_pix, notes.pop_front());
        end
        if (d_fault === 1'b1 && fault_q === 1'b0)
            faults++;
        pclk_q = d_pclk;
        fault_q = d_fault;
    end

    initial
    begin
        #400_000;
        bad_count++;
        $display("[FAIL] watchdog expected done seen timeout");
        test_done();
    end

    initial
    begin
        {seed, bad_count, compares, rises, faults} = {32'd64, 128'h0};
        {arst_n, pd_n, sel_ser, stb, bad_seq, bad_par, pclk_q, fault_q} = 8'h40;
        pix = 21'h0;
        spix = 21'h0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        wait_sync();
        stream(3);
        check("fault pulses", faults, 0);
        frame(1'b0, 1'b1);
        frame(1'b0, 1'b0);
        repeat (30) @(posedge lclk);
        check("fault pulses", faults, 1);
        // three bad, one good, three bad: only a refill keeps sync
        repeat (3) frame(1'b1, 1'b0);
        frame(1'b0, 1'b0);
        repeat (3) frame(1'b1, 1'b0);
        frame(1'b0, 1'b0);
        count_rises(60, 10, "rises held");
        repeat (4) frame(1'b1, 1'b0);
        repeat (2) frame(1'b0, 1'b0);
        count_rises(18, 0, "rises lost");
        wait_sync();
        stream(2);
        @(posedge clk);
        pd_n <= 1'b0;
        repeat (10) @(posedge lclk);
        check("pix off", d_pix, 21'h0);
        check("pclk off", d_pclk, 1'b0);
        check("forward off", s_fwd, 1'b0);
        @(posedge lclk);
        sel_ser <= 1'b1;
        @(posedge clk);
        pd_n <= 1'b1;
        wait_sync();
        stream(3);
        check("fault pulses", faults, 1);
        test_done();
    end
endmodule
